// [rtl/hpp_pkg.sv]
// Constants, register map and carrier types of the hub port power and strap controller.
// Assumes a single 100 MHz clock and an AXI4-Lite master with 32-bit data.
//
// Operation
// - While the active-low external reset pin is low, all logic returns to its initial state.
// - The supply select input reads 0 as bus powered and 1 as self powered.
// - After reset the mode pin stays an input until its strap level has been sampled.
// - A mode strap of 1 selects ganged mode; the pin then drives 0 normally, 1 in suspend.
// - A mode strap of 0 selects individual mode; the pin then drives 1 normally, 0 in suspend.
// - The test input reads 0 for normal running and 1 for test mode.
// - Each port power enable is active low by default and goes low to power the port.
// - A low level on a port's overcurrent sense input means overcurrent on that port.
// - In ganged mode only the first port's overcurrent input is used; the others are ignored.
package hpp_pkg;

    // ==================================================================
    // Sizes and timing
    localparam int unsigned NUM_PORTS       = 4;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned STRAP_SETTLE_NS = 1000;
    localparam int unsigned STRAP_CYCLES    =
        (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STRAP_CNT_W     = 8;

    // ==================================================================
    // Register map, byte addresses
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_ISTAT  = 4'h8;
    localparam logic [3:0] REG_IMASK  = 4'hc;

    // Control register fields.
    localparam int unsigned CTRL_PORT_EN_LSB = 0;
    localparam int unsigned CTRL_SUSPEND_BIT = 4;
    localparam int unsigned CTRL_POL_BIT     = 5;
    localparam logic [5:0]  CTRL_RESET       = 6'h00;

    // Interrupt status fields: one overcurrent event per port, then supply change.
    localparam int unsigned IRQ_W          = 5;
    localparam int unsigned IRQ_SUPPLY_BIT = 4;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==================================================================
    // Types
    typedef enum logic {HPP_ST_STRAP, HPP_ST_RUN} hpp_state_e;

    // Pin inputs that cross into the clock domain together.
    typedef struct packed {
        logic [NUM_PORTS-1:0] oc_n;
        logic                 mode;
        logic                 supply;
        logic                 test;
    } hpp_pins_s;

    localparam hpp_pins_s PINS_IDLE = '{oc_n: 4'hf, mode: 1'b0, supply: 1'b0, test: 1'b0};

endpackage

// [rtl/hpp_top.sv]
// Port power switch, overcurrent and strap controller of a four-port hub.
// Assumes pins are asynchronous to mclk and software uses AXI4-Lite.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module hpp_top
(
    // Clock and resets
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          ext_reset_n,
    // Strap and configuration pins
    input  wire logic                          supply_source_select,
    input  wire logic                          test_mode_in,
    input  wire logic                          mode_pin_in,
    output logic                               mode_pin_out,
    output logic                               mode_pin_oe,
    // Port power switches and overcurrent sensors
    output logic [hpp_pkg::NUM_PORTS-1:0]      port_power_enable_n,
    input  wire logic [hpp_pkg::NUM_PORTS-1:0] overcurrent_sense_n,
    // Interrupt
    output logic                               irq,
    // AXI4-Lite slave
    input  wire logic [3:0]                    s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [3:0]                    s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready
);
    import hpp_pkg::*;

    function automatic logic is_mapped(input logic [3:0] a);
        is_mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_ISTAT) || (a == REG_IMASK);
    endfunction

    // ==================================================================
    // Reset and pin synchronisers
    logic       rstn_s1_q;
    logic       rstn_s2_q;
    logic       int_rst;
    hpp_pins_s  pins_now;
    hpp_pins_s  pins_s1_q;
    hpp_pins_s  pins_s2_q;
    hpp_pins_s  pins_s3_q;

    // Only rst clears this pair, so the pin release is seen two edges late.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rstn_s1_q <= 1'b0;
            rstn_s2_q <= 1'b0;
        end
        else
        begin
            rstn_s1_q <= ext_reset_n;
            rstn_s2_q <= rstn_s1_q;
        end
    end

    assign int_rst = rst || !rstn_s2_q;

    assign pins_now = '{oc_n: overcurrent_sense_n, mode: mode_pin_in,
                        supply: supply_source_select, test: test_mode_in};

    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            pins_s1_q <= PINS_IDLE;
            pins_s2_q <= PINS_IDLE;
            pins_s3_q <= PINS_IDLE;
        end
        else
        begin
            pins_s1_q <= pins_now;
            pins_s2_q <= pins_s1_q;
            pins_s3_q <= pins_s2_q;
        end
    end

    // ==================================================================
    // Strap capture
    hpp_state_e             state_q;
    logic [STRAP_CNT_W-1:0] strap_cnt_q;
    logic                   gang_mode_q;

    // The pad stays an input for the settle time so the strap resistor wins cleanly.
    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            state_q     <= HPP_ST_STRAP;
            strap_cnt_q <= '0;
            gang_mode_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                HPP_ST_STRAP:
                begin
                    if (strap_cnt_q == STRAP_CNT_W'(STRAP_CYCLES - 1))
                    begin
                        gang_mode_q <= pins_s2_q.mode;
                        state_q     <= HPP_ST_RUN;
                    end
                    else
                    begin
                        strap_cnt_q <= strap_cnt_q + STRAP_CNT_W'(1);
                    end
                end
                HPP_ST_RUN:
                begin
                    state_q <= HPP_ST_RUN;
                end
                default:
                begin
                    state_q <= HPP_ST_STRAP;
                end
            endcase
        end
    end

    // ==================================================================
    // Registers written by software
    logic [NUM_PORTS-1:0] port_en_q;
    logic                 suspend_q;
    logic                 pol_high_q;
    logic [IRQ_W-1:0]     istat_q;
    logic [IRQ_W-1:0]     imask_q;
    logic [3:0]           awaddr_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    logic                 aw_have_q;
    logic                 w_have_q;
    logic                 wr_fire;
    logic                 wr_low;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_low  = wr_fire && wstrb_q[0];

    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            {pol_high_q, suspend_q, port_en_q} <= CTRL_RESET;
        end
        else if (wr_low && awaddr_q == REG_CTRL)
        begin
            port_en_q  <= wdata_q[CTRL_PORT_EN_LSB +: NUM_PORTS];
            suspend_q  <= wdata_q[CTRL_SUSPEND_BIT];
            pol_high_q <= wdata_q[CTRL_POL_BIT];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            imask_q <= '0;
        end
        else if (wr_low && awaddr_q == REG_IMASK)
        begin
            imask_q <= wdata_q[IRQ_W-1:0];
        end
    end

    // ==================================================================
    // Overcurrent and supply events
    logic [NUM_PORTS-1:0] oc_now;
    logic [NUM_PORTS-1:0] oc_prev;
    logic [IRQ_W-1:0]     ev_set;
    logic [IRQ_W-1:0]     ev_clr;

    // In ganged mode port one's sensor stands for every port.
    assign oc_now  = gang_mode_q ? {NUM_PORTS{~pins_s2_q.oc_n[0]}} : ~pins_s2_q.oc_n;
    assign oc_prev = gang_mode_q ? {NUM_PORTS{~pins_s3_q.oc_n[0]}} : ~pins_s3_q.oc_n;

    // Only port one's event is flagged in ganged mode; one sensor, one event.
    assign ev_set[NUM_PORTS-1:0] = (state_q == HPP_ST_RUN) ?
        (oc_now & ~oc_prev & (gang_mode_q ? NUM_PORTS'(1) : {NUM_PORTS{1'b1}})) : '0;
    assign ev_set[IRQ_SUPPLY_BIT] = (state_q == HPP_ST_RUN) &&
        (pins_s2_q.supply != pins_s3_q.supply);
    assign ev_clr = (wr_low && awaddr_q == REG_ISTAT) ? wdata_q[IRQ_W-1:0] : '0;

    // A new event beats a simultaneous write-one-to-clear.
    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            istat_q <= '0;
        end
        else
        begin
            istat_q <= (istat_q & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(istat_q & imask_q);
        end
    end

    // ==================================================================
    // Pin drivers
    logic [NUM_PORTS-1:0] pwr_on_d;

    // Test mode and a live overcurrent hold the switches off; the sensor release restores them.
    assign pwr_on_d = (state_q == HPP_ST_RUN && !pins_s2_q.test) ?
        ((gang_mode_q ? {NUM_PORTS{port_en_q[0]}} : port_en_q) & ~oc_now) : '0;

    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            port_power_enable_n <= {NUM_PORTS{1'b1}};
        end
        else
        begin
            port_power_enable_n <= pol_high_q ? pwr_on_d : ~pwr_on_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            mode_pin_oe  <= 1'b0;
            mode_pin_out <= 1'b0;
        end
        else
        begin
            mode_pin_oe  <= (state_q == HPP_ST_RUN);
            mode_pin_out <= gang_mode_q ? suspend_q : !suspend_q;
        end
    end

    // ==================================================================
    // AXI4-Lite write channels
    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wstrb_q       <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            // Readies stay low while reset would swallow a request, and rise on the first
            // free edge; a handshake below overrides this in the same edge.
            if (!aw_have_q && !w_have_q && !s_axi_bvalid)
            begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q     <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (is_mapped(awaddr_q) && awaddr_q != REG_STATUS) ?
                                RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ==================================================================
    // AXI4-Lite read channels
    logic [31:0] rd_word;

    always_comb
    begin
        rd_word = '0;
        case (s_axi_araddr)
            REG_CTRL:   rd_word[5:0] = {pol_high_q, suspend_q, port_en_q};
            REG_STATUS: rd_word[7:0] = {oc_now, state_q == HPP_ST_RUN, pins_s2_q.test,
                                        pins_s2_q.supply, gang_mode_q};
            REG_ISTAT:  rd_word[IRQ_W-1:0] = istat_q;
            REG_IMASK:  rd_word[IRQ_W-1:0] = imask_q;
            default:    rd_word = '0;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (int_rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        else if (!s_axi_rvalid)
        begin
            s_axi_arready <= 1'b1;
        end
    end

    // ==================================================================
    // Assertions
    a_reset_powers_off: assert property (@(posedge mclk) int_rst |=>
        (port_power_enable_n == {NUM_PORTS{1'b1}} && !mode_pin_oe && !irq))
        else $error("reset did not return outputs to idle");

    a_ext_reset_sync: assert property (@(posedge mclk) disable iff (rst)
        (!ext_reset_n ##3 1'b1) |-> state_q == HPP_ST_STRAP && strap_cnt_q == '0)
        else $error("external reset not applied three edges later");

    a_supply_status: assert property (@(posedge mclk) disable iff (int_rst)
        pins_s2_q.supply |-> rd_word[1] || s_axi_araddr != REG_STATUS)
        else $error("self powered not reported");

    a_strap_input: assert property (@(posedge mclk) disable iff (int_rst)
        (state_q == HPP_ST_STRAP) |=> !mode_pin_oe)
        else $error("mode pin driven before strap capture");

    a_gang_level: assert property (@(posedge mclk) disable iff (int_rst)
        (state_q == HPP_ST_RUN && gang_mode_q) |=> mode_pin_oe && mode_pin_out == $past(suspend_q))
        else $error("ganged mode pin level wrong");

    a_indiv_level: assert property (@(posedge mclk) disable iff (int_rst)
        (state_q == HPP_ST_RUN && !gang_mode_q) |=> mode_pin_out == !$past(suspend_q))
        else $error("individual mode pin level wrong");

    a_test_off: assert property (@(posedge mclk) disable iff (int_rst)
        (pins_s2_q.test && !pol_high_q) |=> port_power_enable_n == {NUM_PORTS{1'b1}})
        else $error("port powered in test mode");

    a_enable_low: assert property (@(posedge mclk) disable iff (int_rst)
        (!pol_high_q && pwr_on_d[0]) |=> !port_power_enable_n[0])
        else $error("power enable not driven low");

    a_oc_event: assert property (@(posedge mclk) disable iff (int_rst)
        (state_q == HPP_ST_RUN && !gang_mode_q && $fell(pins_s2_q.oc_n[2])) |=> istat_q[2])
        else $error("overcurrent on port three not flagged");

    a_gang_ignore: assert property (@(posedge mclk) disable iff (int_rst)
        (gang_mode_q && !istat_q[3]) |=> !istat_q[3])
        else $error("port four sensor used in ganged mode");

    c_gang_run:    cover property (@(posedge mclk) state_q == HPP_ST_RUN && gang_mode_q);
    c_indiv_run:   cover property (@(posedge mclk) state_q == HPP_ST_RUN && !gang_mode_q);
    c_oc_irq:      cover property (@(posedge mclk) $rose(irq));
    c_suspend_out: cover property (@(posedge mclk) mode_pin_oe && suspend_q);

endmodule

// [testbench/hpp_far_side.sv]
// Far side of the pins: mode strap resistor and overcurrent sensors.
// Assumes the bench sets the strap level and fault commands right after a clock edge.
`timescale 1ns/100ps

module hpp_far_side
(
    // Clock
    input  wire logic                          mclk,
    // Commands from the bench
    input  wire logic                          strap_level,
    input  wire logic [hpp_pkg::NUM_PORTS-1:0] fault_cmd,
    // Device pins
    input  wire logic                          mode_pin_out,
    input  wire logic                          mode_pin_oe,
    output logic                               mode_pin_in,
    output logic [hpp_pkg::NUM_PORTS-1:0]      overcurrent_sense_n
);
    import hpp_pkg::*;

    // =====================================================================
    // Mode pad
    // The strap resistor only sets the level while the device leaves the pad alone.
    assign mode_pin_in = mode_pin_oe ? mode_pin_out : strap_level;

    // =====================================================================
    // Sensors
    // Open-drain sensors: the pull-up holds the line high unless a fault pulls it low.
    always_ff @(posedge mclk)
    begin
        overcurrent_sense_n <= ~fault_cmd;
    end
endmodule

// [testbench/tb.sv]
// Self-checking bench of the port power and strap controller.
// Assumes the far-side model in hpp_far_side and an AXI4-Lite master in the bench.
`timescale 1ns/100ps

module tb;
    import hpp_pkg::*;

    // =====================================================================
    // Signals
    logic        mclk = 0, rst = 1, ext_reset_n = 1, supply = 0, test_in = 0;
    logic        strap = 1, mode_in, mode_out, mode_oe, irq;
    logic [3:0]  fault = 0, pwr_n, oc_n;
    logic [3:0]  awaddr = 0, araddr = 0, wstrb = 4'hf;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 0, rdata;
    logic [1:0]  bresp, rresp;
    int          n_mismatch = 0, total_checks = 0, cycles = 0;

    always #5 mclk = ~mclk;

    hpp_top hpp_top_inst (.mclk(mclk), .rst(rst), .ext_reset_n(ext_reset_n),
        .supply_source_select(supply), .test_mode_in(test_in), .mode_pin_in(mode_in),
        .mode_pin_out(mode_out), .mode_pin_oe(mode_oe), .port_power_enable_n(pwr_n),
        .overcurrent_sense_n(oc_n), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    hpp_far_side hpp_far_side_inst (.mclk(mclk), .strap_level(strap), .fault_cmd(fault),
        .mode_pin_out(mode_out), .mode_pin_oe(mode_oe), .mode_pin_in(mode_in),
        .overcurrent_sense_n(oc_n));

    // =====================================================================
    // Common tasks
    task automatic end_of_test();
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Address and data go out together; each is dropped at the edge that takes it.
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_p, w_p, b_p;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_p = 1;
        w_p = 1;
        b_p = 1;
        while (aw_p || w_p || b_p)
        begin
            @(posedge mclk);
            if (aw_p && awready)
            begin
                awvalid <= 1'b0;
                aw_p = 0;
            end
            if (w_p && wready)
            begin
                wvalid <= 1'b0;
                w_p = 0;
            end
            if (b_p && bvalid)
            begin
                bready <= 1'b0;
                b_p = 0;
                chk("bresp", {30'h0, er}, {30'h0, bresp});
            end
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_p, r_p;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ar_p = 1;
        r_p = 1;
        while (ar_p || r_p)
        begin
            @(posedge mclk);
            if (ar_p && arready)
            begin
                arvalid <= 1'b0;
                ar_p = 0;
            end
            if (r_p && rvalid)
            begin
                rready <= 1'b0;
                r_p = 0;
                chk("rdata", ed, rdata);
                chk("rresp", {30'h0, er}, {30'h0, rresp});
            end
        end
    endtask

    // =====================================================================
    // Scenarios
    // The pad must still be an input 50 cycles after the task starts, then report the strap.
    task automatic t_strap(input logic gang);
        int n;
        tick(50);
        chk("oe_wait", 0, mode_oe);
        chk("pwr_wait", 4'hf, pwr_n);
        n = 0;
        while (mode_oe !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        chk("oe_run", 1, mode_oe);
        rd(REG_STATUS & 4'hf, {28'h0, 2'b10, supply, gang}, RESP_OKAY);
    endtask

    task automatic t_bus();
        rd(REG_CTRL, 0, RESP_OKAY);
        rd(REG_IMASK, 0, RESP_OKAY);
        rd(4'h6, 0, RESP_SLVERR);
        wr(REG_STATUS, 32'hff, RESP_SLVERR);
        wstrb <= 4'he;
        wr(REG_IMASK, 32'h1f, RESP_OKAY);
        wstrb <= 4'hf;
        rd(REG_IMASK, 0, RESP_OKAY);
    endtask

    task automatic t_gang();
        wr(REG_CTRL, 32'h10, RESP_OKAY);
        tick(3);
        chk("mode_susp", 1, mode_out);
        wr(REG_CTRL, 32'h0f, RESP_OKAY);
        tick(4);
        chk("mode_norm", 0, mode_out);
        chk("pwr_on", 4'h0, pwr_n);
        fault <= 4'he;
        tick(6);
        chk("pwr_ign", 4'h0, pwr_n);
        rd(REG_STATUS, 32'h09, RESP_OKAY);
        rd(REG_ISTAT, 32'h00, RESP_OKAY);
        fault <= 4'h1;
        tick(6);
        chk("pwr_oc", 4'hf, pwr_n);
        rd(REG_STATUS, 32'hf9, RESP_OKAY);
        rd(REG_ISTAT, 32'h01, RESP_OKAY);
        wr(REG_IMASK, 32'h01, RESP_OKAY);
        tick(3);
        chk("irq_set", 1, irq);
        fault <= 4'h0;
        tick(6);
        chk("pwr_back", 4'h0, pwr_n);
        wr(REG_ISTAT, 32'h01, RESP_OKAY);
        tick(3);
        chk("irq_clr", 0, irq);
        wr(REG_CTRL, 32'h20, RESP_OKAY);
        tick(4);
        chk("pwr_pol", 4'h0, pwr_n);
        wr(REG_CTRL, 32'h0f, RESP_OKAY);
    endtask

    task automatic t_pins();
        test_in <= 1'b1;
        tick(6);
        chk("pwr_test", 4'hf, pwr_n);
        rd(REG_STATUS, 32'h0d, RESP_OKAY);
        test_in <= 1'b0;
        supply <= 1'b1;
        wr(REG_IMASK, 32'h10, RESP_OKAY);
        tick(6);
        chk("pwr_run", 4'h0, pwr_n);
        rd(REG_STATUS, 32'h0b, RESP_OKAY);
        rd(REG_ISTAT, 32'h10, RESP_OKAY);
        chk("irq_sup", 1, irq);
        wr(REG_ISTAT, 32'h10, RESP_OKAY);
        tick(3);
        chk("irq_sclr", 0, irq);
    endtask

    // A board reset in mid-run must drop everything and capture a new strap.
    task automatic t_indiv();
        ext_reset_n <= 1'b0;
        strap <= 1'b0;
        tick(6);
        chk("oe_rst", 0, mode_oe);
        chk("pwr_rst", 4'hf, pwr_n);
        ext_reset_n <= 1'b1;
        t_strap(1'b0);
        rd(REG_CTRL, 0, RESP_OKAY);
        wr(REG_CTRL, 32'h0f, RESP_OKAY);
        tick(4);
        chk("mode_ind", 1, mode_out);
        fault <= 4'h4;
        tick(6);
        chk("pwr_ind", 4'h4, pwr_n);
        rd(REG_ISTAT & 4'hf, 32'h04, RESP_OKAY);
        wr(REG_CTRL, 32'h1f, RESP_OKAY);
        tick(3);
        chk("mode_isusp", 0, mode_out);
    endtask

    // =====================================================================
    // Main sequence and hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles >= 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial
    begin
        tick(3);
        rst <= 1'b0;
        t_bus();
        t_strap(1'b1);
        t_gang();
        t_pins();
        t_indiv();
        end_of_test();
    end
endmodule
